/* File: shared/flyback_pkg.sv */
/*
  constants, states and register layout of the flyback supervisory block.
  assumes a single 25 mhz system clock and a plain register port.
*/
package flyback_pkg;

  // system clock rate
  localparam int CLK_KHZ = 25000;

  // dead time limit for valley turn-on, in microseconds
  localparam int DEAD_LIMIT_US = 32;
  localparam int DEAD_CYC = DEAD_LIMIT_US * CLK_KHZ / 1000;
  localparam int DEAD_W = 10;

  // output undervoltage persistence, in milliseconds
  localparam int UV_TIME_MS = 64;
  localparam int UV_CYC = UV_TIME_MS * CLK_KHZ;
  localparam int UV_W = 21;

  // consecutive over-threshold switching cycles before a trip
  localparam logic [1:0] OVP_CYCLES = 2'h3;

  // dither: 2 switching cycles per level, 12 per pattern
  localparam logic [3:0] DITHER_PERIOD = 4'hc;
  localparam int DITHER_STEP_SHIFT = 1;
  // trim in tenths of a percent around the mean reference
  localparam logic signed [7:0] TRIM_LOWEST = -8'sd30;
  localparam logic signed [7:0] TRIM_LOW = -8'sd10;
  localparam logic signed [7:0] TRIM_HIGH = 8'sd10;
  localparam logic signed [7:0] TRIM_HIGHEST = 8'sd30;

  // supervisory states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_AUTO_REC,
    ST_THERM_HOLD,
    ST_FAST_REC
  } sup_state_e;

  // register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // status bit positions
  localparam int EV_SUPPLY_OVP = 0;
  localparam int EV_OUT_OVP = 1;
  localparam int EV_OUT_UVP = 2;
  localparam int EV_JUNCTION = 3;
  localparam int EV_THERMISTOR = 4;
  localparam int EV_W = 5;

endpackage

/* File: src/pin_sync.sv */
/*
  two-stage synchroniser for a group of comparator levels.
  assumes inputs change asynchronously to sys_clk_i.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [W-1:0] async_i, // raw levels
  output logic [W-1:0] sync_o // synchronised levels
);

  logic [W-1:0] meta_r;

  // first stage read only by the second
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // pin_sync

/* File: src/dither_seq.sv */
/*
  triangular dither sequencer for the current-sense reference.
  assumes adv_i is a one-cycle pulse per completed switching cycle.
*/
`timescale 1ns/1ps
module dither_seq
  import flyback_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic adv_i, // switching cycle completed
  output logic [1:0] level_o, // 0 lowest .. 3 highest
  output logic signed [7:0] trim_o // offset in 0.1 percent
);

  typedef struct packed {
    logic [3:0] step;
    logic [1:0] level;
    logic signed [7:0] trim;
  } dith_s;

  dith_s q, d;

  // step index to level: up through four levels, back down
  function automatic logic [1:0] step_level(input logic [3:0] s);
    logic [2:0] h;
    h = 3'(s >> DITHER_STEP_SHIFT);
    step_level = (h > 3'h3) ? 2'(3'h6 - h) : h[1:0];
  endfunction

  // level to trim span of plus and minus three percent
  function automatic logic signed [7:0] level_trim(input logic [1:0] l);
    unique case (l)
      2'h0: level_trim = TRIM_LOWEST;
      2'h1: level_trim = TRIM_LOW;
      2'h2: level_trim = TRIM_HIGH;
      2'h3: level_trim = TRIM_HIGHEST;
    endcase
  endfunction

  // advance only on completed cycles, wrap after twelve
  always_comb begin
    d = q;
    if (adv_i) begin // [RQ2] [RQ13]
      d.step = (q.step == DITHER_PERIOD - 4'h1) ? 4'h0 : q.step + 4'h1;
    end
    d.level = step_level(d.step); // [RQ13]
    d.trim = level_trim(d.level); // [RQ3]
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{step: 4'h0, level: 2'h0, trim: TRIM_LOWEST};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;
  assign trim_o = q.trim;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  step_hold_a: assert property ( // [RQ2]
    !adv_i |=> $stable(q.step)) else $error("dither step moved without cycle");
  level_pair_a: assert property ( // [RQ2]
    (adv_i && !q.step[0]) |=> $stable(q.level))
    else $error("dither level changed mid pair");
  trim_span_a: assert property ( // [RQ3]
    q.level == 2'h3 |-> q.trim == TRIM_HIGHEST)
    else $error("top level not at plus three percent");
  wrap_c: cover property (adv_i && q.step == DITHER_PERIOD - 4'h1);

endmodule // dither_seq

/* File: src/flyback_protection_jitter_control.sv */
/*
  supervisory logic of a primary-side flyback controller: fault states,
  valley permission, line compensation switch, reference dither, irq.
  assumes comparator and cycle inputs are asynchronous pins and software
  uses the plain register port on the same 25 mhz clock.
*/
`timescale 1ns/1ps
// How it works
// RQ1 - valley turn-on allowed only if previous dead time under 32 us.
// RQ2 - dither reference steps every 2 cycles, pattern repeats every 12.
// RQ3 - dither levels span plus and minus three percent about the mean.
// RQ4 - line compensation switch closed only during primary on-time.
// RQ5 - auto-recovery stops switching, restarts at minimum supply level.
// RQ6 - supply overvoltage removes gate drive at once, enters auto-recovery.
// RQ7 - feedback over threshold 3 consecutive cycles trips output overvoltage.
// RQ8 - feedback under threshold for 64 ms trips output undervoltage.
// RQ9 - junction over-temperature stops switching and enters hold.
// RQ10 - hold is left only once junction cooled by the hysteresis margin.
// RQ11 - thermistor pin below shutdown threshold enters fast auto-recovery.
// RQ12 - fast auto-recovery held until thermistor pin above recovery level.
// RQ13 - dither is a triangle of six two-cycle steps, completed cycles only.
// RQ14 - overvoltage count clears on a low sample, uv timer on recovery.
module flyback_protection_jitter_control
  import flyback_pkg::*;
#(
  parameter int UV_LIMIT_CYC = UV_CYC // shorten in simulation
) (
  input wire logic sys_clk_i, // 25 mhz system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic sw_cycle_i, // high during each switching cycle end
  input wire logic on_req_i, // pwm core asks for primary on-time
  input wire logic dead_time_i, // high while neither side conducts
  input wire logic supply_ovp_i, // supply overvoltage comparator
  input wire logic fb_ovp_i, // feedback sample above ov threshold
  input wire logic fb_uvp_i, // feedback sample below uv threshold
  input wire logic min_supply_i, // supply fell to minimum operating
  input wire logic junction_trip_i, // junction at trip temperature
  input wire logic junction_cool_i, // junction below trip less margin
  input wire logic ntc_shutdown_i, // thermistor pin below shutdown
  input wire logic ntc_recover_i, // thermistor pin above recovery
  input wire logic [3:0] addr_i, // register byte address
  input wire logic [7:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  output logic gate_o, // power switch gate drive
  output logic line_comp_switch_o, // line compensation switch
  output logic valley_en_o, // wait for valley before turn-on
  output logic [1:0] dither_level_o, // current dither level
  output logic signed [7:0] dither_trim_o, // reference trim, 0.1 pct
  output logic irq_o // unmasked fault pending
);

  localparam int NPIN = 11;
  localparam logic [DEAD_W-1:0] DEAD_LIM = DEAD_W'(DEAD_CYC);
  localparam logic [DEAD_W-1:0] DEAD_SAT = '1;
  localparam logic [UV_W-1:0] UV_LAST = UV_W'(UV_LIMIT_CYC - 1);

  typedef struct packed {
    sup_state_e st;
    logic [1:0] ovp_cnt;
    logic [UV_W-1:0] uv_cnt;
    logic [DEAD_W-1:0] dead_cnt;
    logic valley;
    logic gate;
    logic lcs;
    logic cyc_d;
    logic dead_d;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [7:0] rdata;
    logic irq;
  } sup_s;

  sup_s q, d;
  logic [NPIN-1:0] pin_s;
  logic cyc_s, on_s, dead_s, vovp_s, fovp_s, fuvp_s;
  logic vmin_s, jtrip_s, jcool_s, nshut_s, nrec_s;
  logic cyc_pulse, dead_end, ovp_trip, uv_trip;
  logic [EV_W-1:0] ev, clr;

  // every comparator and power stage pin passes two flip-flops; the register strobes wr_i and rd_i do not
  pin_sync #(.W(NPIN)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({sw_cycle_i, on_req_i, dead_time_i, supply_ovp_i, fb_ovp_i,
              fb_uvp_i, min_supply_i, junction_trip_i, junction_cool_i,
              ntc_shutdown_i, ntc_recover_i}),
    .sync_o(pin_s)
  );

  assign {cyc_s, on_s, dead_s, vovp_s, fovp_s, fuvp_s, vmin_s, jtrip_s,
          jcool_s, nshut_s, nrec_s} = pin_s;

  // rising edge of the cycle strobe marks one completed cycle
  assign cyc_pulse = cyc_s && !q.cyc_d;
  assign dead_end = !dead_s && q.dead_d;

  dither_seq u_dither (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .adv_i(cyc_pulse), // [RQ13]
    .level_o(dither_level_o),
    .trim_o(dither_trim_o)
  );

  // register address match, shared by write and read decode
  function automatic logic reg_hit(input logic [3:0] a,
                                   input logic [3:0] off);
    reg_hit = (a == off);
  endfunction

  // trip conditions seen this cycle while switching
  assign ovp_trip = cyc_pulse && fovp_s &&
                    (q.ovp_cnt == OVP_CYCLES - 2'h1); // [RQ7]
  assign uv_trip = fuvp_s && (q.uv_cnt == UV_LAST); // [RQ8]

  // next state of the whole block
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    d.cyc_d = cyc_s;
    d.dead_d = dead_s;

    // dead time length of the cycle just ended
    if (dead_s) begin
      d.dead_cnt = (q.dead_cnt == DEAD_SAT) ? q.dead_cnt
                                             : q.dead_cnt + 1'b1;
    end else if (dead_end) begin
      d.valley = (q.dead_cnt < DEAD_LIM); // [RQ1]
      d.dead_cnt = '0;
    end

    // supervisory state machine, junction first, then thermistor
    unique case (q.st)
      ST_RUN: begin
        if (jtrip_s) begin
          d.st = ST_THERM_HOLD; // [RQ9]
          ev[EV_JUNCTION] = 1'b1;
        end else if (nshut_s) begin
          d.st = ST_FAST_REC; // [RQ11]
          ev[EV_THERMISTOR] = 1'b1;
        end else if (vovp_s) begin
          d.st = ST_AUTO_REC; // [RQ6]
          ev[EV_SUPPLY_OVP] = 1'b1;
        end else if (ovp_trip) begin
          d.st = ST_AUTO_REC; // [RQ7]
          ev[EV_OUT_OVP] = 1'b1;
        end else if (uv_trip) begin
          d.st = ST_AUTO_REC; // [RQ8]
          ev[EV_OUT_UVP] = 1'b1;
        end
      end
      ST_AUTO_REC: begin
        if (jtrip_s) begin
          d.st = ST_THERM_HOLD;
          ev[EV_JUNCTION] = 1'b1;
        end else if (nshut_s) begin
          d.st = ST_FAST_REC;
          ev[EV_THERMISTOR] = 1'b1;
        end else if (vmin_s && !vovp_s) begin
          d.st = ST_RUN; // [RQ5]
        end
      end
      ST_THERM_HOLD: begin
        if (jcool_s && !jtrip_s) begin
          d.st = ST_RUN; // [RQ10]
        end
      end
      ST_FAST_REC: begin
        if (jtrip_s) begin
          d.st = ST_THERM_HOLD;
          ev[EV_JUNCTION] = 1'b1;
        end else if (nrec_s && !nshut_s) begin
          d.st = ST_RUN; // [RQ12]
        end
      end
    endcase

    // fault counters run only while switching
    if (q.st != ST_RUN || d.st != ST_RUN) begin
      d.ovp_cnt = '0;
      d.uv_cnt = '0;
    end else begin
      if (cyc_pulse) begin
        d.ovp_cnt = fovp_s ? q.ovp_cnt + 2'h1 : 2'h0; // [RQ14]
      end
      d.uv_cnt = fuvp_s ? q.uv_cnt + 1'b1 : '0; // [RQ14]
    end

    // drive falls in the cycle a stop condition is seen
    d.gate = (d.st == ST_RUN) && on_s && !vovp_s && !jtrip_s &&
             !nshut_s; // [RQ6] [RQ9] [RQ11]
    d.lcs = d.gate; // [RQ4]

    // write side: mask stores, status clears by writing ones
    if (wr_i && reg_hit(addr_i, REG_MASK)) begin
      d.mask = wdata_i[EV_W-1:0];
    end
    if (wr_i && reg_hit(addr_i, REG_STATUS)) begin
      clr = wdata_i[EV_W-1:0];
    end
    d.status = (q.status & ~clr) | ev; // new event beats clear
    d.irq = |(d.status & d.mask);

    // read side: data stands for one cycle only
    d.rdata = '0;
    if (rd_i) begin
      if (reg_hit(addr_i, REG_STATUS)) begin
        d.rdata = 8'(q.status);
      end else if (reg_hit(addr_i, REG_MASK)) begin
        d.rdata = 8'(q.mask);
      end else if (reg_hit(addr_i, REG_STATE)) begin
        d.rdata = {3'h0, q.valley, dither_level_o, q.st};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: ST_AUTO_REC, ovp_cnt: 2'h0, uv_cnt: '0, dead_cnt: '0,
             valley: 1'b0, gate: 1'b0, lcs: 1'b0, cyc_d: 1'b0,
             dead_d: 1'b0, status: '0, mask: MASK_RESET, rdata: 8'h00,
             irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rdata_o = q.rdata;
  assign gate_o = q.gate;
  assign line_comp_switch_o = q.lcs;
  assign valley_en_o = q.valley;
  assign irq_o = q.irq;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  valley_limit_a: assert property ( // [RQ1]
    dead_end && q.dead_cnt >= DEAD_LIM |=> !valley_en_o)
    else $error("valley allowed after long dead time");
  lcs_follows_a: assert property ( // [RQ4]
    line_comp_switch_o |-> $past(on_s) && q.st == ST_RUN)
    else $error("line switch closed outside on-time");
  auto_restart_a: assert property ( // [RQ5]
    q.st == ST_AUTO_REC && vmin_s && !vovp_s && !jtrip_s && !nshut_s
    |=> q.st == ST_RUN && gate_o == $past(on_s))
    else $error("no restart at minimum supply");
  supply_ovp_a: assert property ( // [RQ6]
    vovp_s |=> !gate_o) else $error("drive kept during supply ov");
  ovp_count_a: assert property ( // [RQ7]
    q.st == ST_RUN && !jtrip_s && !nshut_s && !vovp_s && ovp_trip
    |=> q.st == ST_AUTO_REC && q.status[EV_OUT_OVP])
    else $error("output ov not tripped on third cycle");
  uv_timer_a: assert property ( // [RQ8]
    q.st == ST_RUN && !jtrip_s && !nshut_s && !vovp_s && !ovp_trip &&
    uv_trip |=> q.st == ST_AUTO_REC && q.status[EV_OUT_UVP])
    else $error("output uv not tripped at timeout");
  junction_hold_a: assert property ( // [RQ9]
    jtrip_s |=> q.st == ST_THERM_HOLD && !gate_o)
    else $error("junction trip not held");
  hold_stay_a: assert property ( // [RQ10]
    q.st == ST_THERM_HOLD && !jcool_s |=> q.st == ST_THERM_HOLD)
    else $error("hold left before cooling");
  ntc_fast_a: assert property ( // [RQ11]
    nshut_s && !jtrip_s && q.st != ST_THERM_HOLD
    |=> q.st == ST_FAST_REC && !gate_o)
    else $error("thermistor trip missed");
  fast_stay_a: assert property ( // [RQ12]
    q.st == ST_FAST_REC && !nrec_s && !jtrip_s |=> q.st == ST_FAST_REC)
    else $error("fast recovery left early");
  ovp_clear_a: assert property ( // [RQ14]
    cyc_pulse && !fovp_s |=> q.ovp_cnt == 2'h0)
    else $error("ov count not cleared");
  uv_clear_a: assert property ( // [RQ14]
    !fuvp_s |=> q.uv_cnt == '0) else $error("uv timer not cleared");
  status_set_a: assert property (
    ev[EV_OUT_OVP] |=> q.status[EV_OUT_OVP])
    else $error("event lost against clear");
  irq_level_a: assert property (
    irq_o == |(q.status & q.mask))
    else $error("irq differs from pending faults");

  ovp_trip_c: cover property (ovp_trip && q.st == ST_RUN);
  hold_exit_c: cover property (q.st == ST_THERM_HOLD ##1 q.st == ST_RUN);
  fast_exit_c: cover property (q.st == ST_FAST_REC ##1 q.st == ST_RUN);
  restart_c: cover property (q.st == ST_AUTO_REC ##1 q.st == ST_RUN);

endmodule // flyback_protection_jitter_control

/* File: testbench/power_stage_model.sv */
/*
  power stage stand-in: pwm demand, dead time and cycle-end strobe.
  assumes the bench enables it and sets the dead-time length in clocks.
*/
`timescale 1ns/1ps
module power_stage_model (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic run_i, // produce switching cycles
  input wire logic [11:0] dead_len_i, // dead time length in clocks
  output logic on_req_o, // primary on demand
  output logic dead_time_o, // neither side conducts
  output logic sw_cycle_o // cycle end strobe
);
  logic [11:0] cnt_r;
  logic [11:0] len;
  // 10 clocks on, 10 secondary, dead time, 4 clocks strobe
  assign len = 12'h018 + dead_len_i;
  // phase counter, parked at zero while stopped
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      cnt_r <= 12'h000;
    else if (!run_i || cnt_r == len - 12'h001)
      cnt_r <= 12'h000;
    else
      cnt_r <= cnt_r + 12'h001;
  end
  // lines sit low outside their phase, and all low while stopped
  assign on_req_o = run_i && cnt_r < 12'h00a;
  assign dead_time_o = run_i && cnt_r >= 12'h014 &&
                       cnt_r < 12'h014 + dead_len_i;
  assign sw_cycle_o = run_i && cnt_r >= 12'h014 + dead_len_i;
endmodule // power_stage_model

/* File: testbench/tb.sv */
/*
  bench for the flyback supervisory block: register tasks, fault scenes.
  assumes the power stage model drives the cycle and dead-time pins.
*/
`timescale 1ns/1ps
module tb;
  import flyback_pkg::*;
  localparam int UV_LIM = 20;
  logic clk, rst_n, run, on_req, dead_t, sw_cyc;
  logic s_ovp, f_ovp, f_uvp, min_sup, j_trip, j_cool, n_sd, n_rec;
  logic wr, rd, gate, lcs, valley, irq;
  logic [11:0] dead_len;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] dlev;
  logic signed [7:0] dtrim;
  logic [1:0] lev_tab [12] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
                               2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
  logic [7:0] trim_tab [4] = '{TRIM_LOWEST, TRIM_LOW, TRIM_HIGH,
                               TRIM_HIGHEST};
  logic [5:0] ov_seq = 6'h3b; // 1,1,0,1,1,1 from bit 0
  int error_cnt = 0;
  int tests_run = 0;
  int gate_hi = 0;

  flyback_protection_jitter_control #(.UV_LIMIT_CYC(UV_LIM))
    flyback_protection_jitter_control_inst (
    .sys_clk_i(clk), .rst_n_i(rst_n), .sw_cycle_i(sw_cyc),
    .on_req_i(on_req), .dead_time_i(dead_t), .supply_ovp_i(s_ovp),
    .fb_ovp_i(f_ovp), .fb_uvp_i(f_uvp), .min_supply_i(min_sup),
    .junction_trip_i(j_trip), .junction_cool_i(j_cool),
    .ntc_shutdown_i(n_sd), .ntc_recover_i(n_rec), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .gate_o(gate), .line_comp_switch_o(lcs), .valley_en_o(valley),
    .dither_level_o(dlev), .dither_trim_o(dtrim), .irq_o(irq));

  power_stage_model power_stage_model_inst (
    .sys_clk_i(clk), .rst_n_i(rst_n), .run_i(run),
    .dead_len_i(dead_len), .on_req_o(on_req), .dead_time_o(dead_t),
    .sw_cycle_o(sw_cyc));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check8(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read strobe, data compared in the cycle after it
  task automatic exp_reg(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check8(e, rdata & m);
  endtask

  // next cycle-end rise, then time for sync and update
  task automatic wait_cyc;
    int n = 0;
    while (sw_cyc !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    while (sw_cyc !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
      error_cnt++;
    wait_clk(5);
  endtask

  // switch state mirrors the gate in every cycle
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      check8({7'h0, gate}, {7'h0, lcs});
      if (gate === 1'b1)
        gate_hi++;
    end
  end

  // hang guard
  initial begin
    #1000000;
    error_cnt++;
    print_verdict;
  end

  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    dead_len = 12'h014;
    s_ovp = 1'b0;
    f_ovp = 1'b0;
    f_uvp = 1'b0;
    min_sup = 1'b0;
    j_trip = 1'b0;
    j_cool = 1'b1;
    n_sd = 1'b0;
    n_rec = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wait_clk(10);
    #1 check8(8'h00, {7'h0, gate});
    check8(8'he2, dtrim);
    wait_clk(10);
    rst_n <= 1'b1;
    // start waits in auto-recovery for minimum supply
    exp_reg(REG_STATE, 8'h03, 8'h01);
    exp_reg(REG_MASK, 8'hff, {3'h0, MASK_RESET});
    exp_reg(REG_STATUS, 8'hff, 8'h00);
    wait_clk(1);
    min_sup <= 1'b1;
    wait_clk(4);
    exp_reg(REG_STATE, 8'h03, 8'h00);
    reg_wr(REG_MASK, 8'h1f);
    run <= 1'b1;
    $display("test reset done");
    // triangle dither, two cycles a level, twelve a period
    check8(8'h00, {6'h0, dlev});
    for (int k = 1; k <= 24; k++) begin
      wait_cyc;
      check8({6'h0, lev_tab[k % 12]}, {6'h0, dlev});
      check8(trim_tab[lev_tab[k % 12]], dtrim);
    end
    $display("test dither done");
    // valley permission at the dead time limit
    dead_len <= 12'h320;
    wait_cyc;
    check8(8'h00, {7'h0, valley});
    dead_len <= 12'h31f;
    wait_cyc;
    check8(8'h01, {7'h0, valley});
    dead_len <= 12'h014;
    $display("test valley done");
    // supply overvoltage cuts the pulse under way
    wait_cyc;
    min_sup <= 1'b0;
    s_ovp <= 1'b1;
    wait_clk(4);
    #1 check8(8'h00, {7'h0, gate});
    check8(8'h01, {7'h0, irq});
    exp_reg(REG_STATE, 8'h03, 8'h01);
    exp_reg(REG_STATUS, 8'hff, 8'h01);
    wait_clk(1);
    s_ovp <= 1'b0;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h01);
    wait_clk(1);
    min_sup <= 1'b1;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h00);
    reg_wr(REG_STATUS, 8'h01);
    exp_reg(REG_STATUS, 8'hff, 8'h00);
    #1 check8(8'h00, {7'h0, irq});
    $display("test supply done");
    // output overvoltage needs three samples in a row
    wait_clk(1);
    min_sup <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wait_clk(1);
      f_ovp <= ov_seq[i];
      wait_cyc;
      if (i == 4)
        exp_reg(REG_STATUS, 8'hff, 8'h00);
    end
    exp_reg(REG_STATUS, 8'hff, 8'h02);
    exp_reg(REG_STATE, 8'h03, 8'h01);
    wait_clk(1);
    f_ovp <= 1'b0;
    min_sup <= 1'b1;
    reg_wr(REG_STATUS, 8'h02);
    $display("test output ov done");
    // undervoltage timer restarts when the sample recovers
    wait_clk(1);
    min_sup <= 1'b0;
    f_uvp <= 1'b1;
    wait_clk(15);
    f_uvp <= 1'b0;
    wait_clk(3);
    f_uvp <= 1'b1;
    wait_clk(15);
    f_uvp <= 1'b0;
    wait_clk(5);
    exp_reg(REG_STATUS, 8'hff, 8'h00);
    wait_clk(1);
    f_uvp <= 1'b1;
    wait_clk(30);
    exp_reg(REG_STATUS, 8'hff, 8'h04);
    exp_reg(REG_STATE, 8'h03, 8'h01);
    wait_clk(1);
    f_uvp <= 1'b0;
    min_sup <= 1'b1;
    reg_wr(REG_STATUS, 8'h04);
    $display("test output uv done");
    // junction hold, masked then unmasked interrupt
    reg_wr(REG_MASK, 8'h00);
    wait_clk(1);
    j_trip <= 1'b1;
    j_cool <= 1'b0;
    wait_clk(5);
    #1 check8(8'h00, {7'h0, gate});
    check8(8'h00, {7'h0, irq});
    exp_reg(REG_STATE, 8'h03, 8'h02);
    exp_reg(REG_STATUS, 8'hff, 8'h08);
    reg_wr(REG_MASK, 8'h08);
    #1 check8(8'h01, {7'h0, irq});
    wait_clk(1);
    j_trip <= 1'b0;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h02);
    wait_clk(1);
    j_cool <= 1'b1;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h00);
    reg_wr(REG_STATUS, 8'h08);
    #1 check8(8'h00, {7'h0, irq});
    $display("test junction done");
    // thermistor fast recovery with separate exit level
    wait_clk(1);
    n_sd <= 1'b1;
    n_rec <= 1'b0;
    wait_clk(4);
    #1 check8(8'h00, {7'h0, gate});
    exp_reg(REG_STATE, 8'h03, 8'h03);
    exp_reg(REG_STATUS, 8'hff, 8'h10);
    wait_clk(1);
    n_sd <= 1'b0;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h03);
    wait_clk(1);
    n_rec <= 1'b1;
    wait_clk(5);
    exp_reg(REG_STATE, 8'h03, 8'h00);
    $display("test thermistor done");
    // unmapped place reads zero and ignores writes
    reg_wr(4'hc, 8'hff);
    exp_reg(4'hc, 8'hff, 8'h00);
    exp_reg(REG_MASK, 8'hff, 8'h08);
    check8(8'h01, {7'h0, gate_hi != 0});
    $display("test map done");
    print_verdict;
  end
endmodule // tb
